// ### verilog/scrb_top.sv
// sensor control register bank with two-wire serial slave
`timescale 1ns/1ps
`include "scrb_params.svh"

// Notes on behaviour
// - write address 78h, read 79h, byte pairs
// - further write bytes go to next address
// - three-bit page choice selects register page
// - reset bits: chip, clock, link, restart low
// - pad direction bits; float pads in vblank
// - pull select none/down/up; 11 illegal
// - powerdown pin pull-down when bit is 0
// - synth enable, halve clock, bypass, clock enables
// - analog power: synth, pixel, power-down bits
// - exposure 13 bits read-only from loop
// - frame period max of exposure, vblank+height
// - flip rows bit 1, mirror columns bit 0
// - processing enables gate seven blocks
// - four-bit effect select plus effect flags
// - mode 17h swap bits pick Bayer order
// - bypass field picks eight of eleven bits
// - sync polarity bit 1 active high
// - gating bit stops pixel clock in hblank
// - pixel clock polarity inverted when bit 0
// - scaler column mode bit 1, general bit 0
// - auto gating control/output, both on
module scrb_top #(
	parameter logic [7:0] ID_HI = 8'hA5, // arbitrary value
	parameter logic [7:0] ID_LO = 8'h5A  // arbitrary value
) (
	input  wire logic             i_mclk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_scl,
	input  wire logic             i_sda,
	output logic                  o_sda_oe,
	output logic                  o_sda_out,
	input  wire logic [12:0]      i_exposure,
	output scrb_pkg::scrb_ctl_s   o_ctl
);
	scrb_pkg::scrb_state_s s_q;
	scrb_pkg::scrb_state_s s_d;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;
	logic [2:0] page;
	logic       reach;
	logic [13:0] vh_sum;

	assign scl_rise = s_q.b.scl_sy[1] & ~s_q.b.scl_sy[2];
	assign scl_fall = ~s_q.b.scl_sy[1] & s_q.b.scl_sy[2];
	assign start_c  = s_q.b.scl_sy[1] & s_q.b.sda_sy[2] & ~s_q.b.sda_sy[1];
	assign stop_c   = s_q.b.scl_sy[1] & ~s_q.b.sda_sy[2] & s_q.b.sda_sy[1];
	assign page     = s_q.r.rst[2:0];
	assign vh_sum   = {1'b0, s_q.r.vb_hi, s_q.r.vb_lo}
		+ {3'h0, s_q.r.wh_hi, s_q.r.wh_lo};

	function automatic logic [7:0] rd_reg(input scrb_pkg::scrb_regs_s r,
			input logic [7:0] a, input logic [2:0] pg,
			input logic [12:0] ex);
		logic [7:0] v;
		v = 8'h00;
		if (a >= `SCRB_SYS_BASE) begin
			case (a)
				`SCRB_A_ID_HI:   v = ID_HI;
				`SCRB_A_ID_LO:   v = ID_LO;
				`SCRB_A_PADDIR:  v = {3'h0, r.paddir};
				`SCRB_A_BUSOPEN: v = {7'h00, r.busopen};
				`SCRB_A_PULL:    v = {2'h0, r.pull, 3'h0, r.pwdn_pull};
				`SCRB_A_PLL1:    v = r.pll1;
				`SCRB_A_PLL2:    v = r.pll2;
				`SCRB_A_CLKEN:   v = r.clken;
				`SCRB_A_CLKDIV:  v = r.clkdiv;
				`SCRB_A_SLVADDR: v = `SCRB_WR_ADDR;
				`SCRB_A_APWR:    v = {5'h00, r.apwr};
				`SCRB_A_SCALE:   v = {6'h00, r.scale};
				`SCRB_A_RST:     v = r.rst;
				default:         v = 8'h00;
			endcase
		end else if (pg == 3'h0) begin
			case (a)
				`SCRB_A_EXP_HI: v = {3'h0, ex[12:8]};
				`SCRB_A_EXP_LO: v = ex[7:0];
				`SCRB_A_HB_HI:  v = {4'h0, r.hb_hi};
				`SCRB_A_HB_LO:  v = r.hb_lo;
				`SCRB_A_VB_HI:  v = {3'h0, r.vb_hi};
				`SCRB_A_VB_LO:  v = r.vb_lo;
				`SCRB_A_ROW_HI: v = {5'h00, r.row_hi};
				`SCRB_A_ROW_LO: v = r.row_lo;
				`SCRB_A_COL_HI: v = {5'h00, r.col_hi};
				`SCRB_A_COL_LO: v = r.col_lo;
				`SCRB_A_WH_HI:  v = {5'h00, r.wh_hi};
				`SCRB_A_WH_LO:  v = r.wh_lo;
				`SCRB_A_WW_HI:  v = {5'h00, r.ww_hi};
				`SCRB_A_WW_LO:  v = r.ww_lo;
				`SCRB_A_FLIP:   v = r.flip;
				`SCRB_A_SKIP:   v = r.skip;
				`SCRB_A_AN3:    v = r.an3;
				`SCRB_A_DRV:    v = r.drv;
				`SCRB_A_EN1:    v = r.en1;
				`SCRB_A_EN2:    v = r.en2;
				`SCRB_A_EN3:    v = r.en3;
				`SCRB_A_EFF:    v = r.eff;
				`SCRB_A_FMT:    v = r.fmt;
				`SCRB_A_FST:    v = r.fst;
				`SCRB_A_SYNC:   v = r.sync;
				`SCRB_A_EN4:    v = {7'h00, r.en4};
				`SCRB_A_GATE:   v = {6'h00, r.gate};
				`SCRB_A_BYP:    v = r.byp;
				`SCRB_A_DBG2:   v = r.dbg2;
				default:        v = 8'h00;
			endcase
		end
		return v;
	endfunction

	function automatic scrb_pkg::scrb_regs_s regs_init();
		scrb_pkg::scrb_regs_s r;
		r = '0;
		r.hb_lo   = `SCRB_R_HB_LO;
		r.vb_lo   = `SCRB_R_VB_LO;
		r.col_lo  = `SCRB_R_COL_LO;
		r.wh_hi   = 3'(`SCRB_R_WH_HI);
		r.wh_lo   = `SCRB_R_WH_LO;
		r.ww_hi   = 3'(`SCRB_R_WW_HI);
		r.ww_lo   = `SCRB_R_WW_LO;
		r.skip    = `SCRB_R_SKIP;
		r.drv     = `SCRB_R_DRV;
		r.en1     = `SCRB_R_EN1;
		r.en2     = `SCRB_R_EN2;
		r.fmt     = `SCRB_R_FMT;
		r.fst     = `SCRB_R_FST;
		r.sync    = `SCRB_R_SYNC;
		r.gate    = 2'(`SCRB_R_GATE);
		r.byp     = `SCRB_R_BYP;
		r.paddir  = 5'(`SCRB_R_PADDIR);
		r.busopen = 1'(`SCRB_R_BUSOPEN);
		r.pll1    = `SCRB_R_PLL1;
		r.pll2    = `SCRB_R_PLL2;
		r.clken   = `SCRB_R_CLKEN;
		r.clkdiv  = `SCRB_R_CLKDIV;
		r.apwr    = 3'(`SCRB_R_APWR);
		return r;
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.b.scl_sy = {s_q.b.scl_sy[1:0], i_scl};
		s_d.b.sda_sy = {s_q.b.sda_sy[1:0], i_sda};
		reach = (s_q.b.ptr >= `SCRB_SYS_BASE) || (page == 3'h0);
		if (start_c) begin
			s_d.b.st = scrb_pkg::ST_ADDR;
			s_d.b.bit_cnt = 4'h0;
			s_d.b.got_addr = 1'b0;
			s_d.b.sda_oe = 1'b0;
		end else if (stop_c) begin
			s_d.b.st = scrb_pkg::ST_IDLE;
			s_d.b.sda_oe = 1'b0;
		end else begin
			case (s_q.b.st)
				scrb_pkg::ST_IDLE: s_d.b.sda_oe = 1'b0;
				scrb_pkg::ST_ADDR, scrb_pkg::ST_DATA: begin
					if (scl_rise) begin
						s_d.b.shift = {s_q.b.shift[6:0], s_q.b.sda_sy[1]};
						s_d.b.bit_cnt = s_q.b.bit_cnt + 4'h1;
					end
					if (scl_fall && s_q.b.bit_cnt == 4'h8) begin
						s_d.b.st = scrb_pkg::ST_ACK;
						s_d.b.sda_oe = 1'b1;
						if (s_q.b.st == scrb_pkg::ST_ADDR) begin
							if (s_q.b.shift == `SCRB_WR_ADDR) begin
								s_d.b.rd = 1'b0;
							end else if (s_q.b.shift == `SCRB_RD_ADDR) begin
								s_d.b.rd = 1'b1;
								s_d.b.rdata = rd_reg(s_q.r, s_q.b.ptr, page,
									i_exposure);
							end else begin
								s_d.b.st = scrb_pkg::ST_IDLE;
								s_d.b.sda_oe = 1'b0;
							end
						end else if (!s_q.b.got_addr) begin
							s_d.b.ptr = s_q.b.shift;
							s_d.b.got_addr = 1'b1;
						end else begin
							s_d.b.ptr = s_q.b.ptr + 8'h01;
							if (reach) begin
								case (s_q.b.ptr)
									`SCRB_A_HB_HI:  s_d.r.hb_hi = s_q.b.shift[3:0];
									`SCRB_A_HB_LO:  s_d.r.hb_lo = s_q.b.shift;
									`SCRB_A_VB_HI:  s_d.r.vb_hi = s_q.b.shift[4:0];
									`SCRB_A_VB_LO:  s_d.r.vb_lo = s_q.b.shift;
									`SCRB_A_ROW_HI: s_d.r.row_hi = s_q.b.shift[2:0];
									`SCRB_A_ROW_LO: s_d.r.row_lo = s_q.b.shift;
									`SCRB_A_COL_HI: s_d.r.col_hi = s_q.b.shift[2:0];
									`SCRB_A_COL_LO: s_d.r.col_lo = s_q.b.shift;
									`SCRB_A_WH_HI:  s_d.r.wh_hi = s_q.b.shift[2:0];
									`SCRB_A_WH_LO:  s_d.r.wh_lo = s_q.b.shift;
									`SCRB_A_WW_HI:  s_d.r.ww_hi = s_q.b.shift[2:0];
									`SCRB_A_WW_LO:  s_d.r.ww_lo = s_q.b.shift;
									`SCRB_A_FLIP:   s_d.r.flip = s_q.b.shift;
									`SCRB_A_SKIP:   s_d.r.skip = s_q.b.shift;
									`SCRB_A_AN3:    s_d.r.an3 = s_q.b.shift;
									`SCRB_A_DRV:    s_d.r.drv = s_q.b.shift;
									`SCRB_A_EN1:    s_d.r.en1 = s_q.b.shift;
									`SCRB_A_EN2:    s_d.r.en2 = s_q.b.shift;
									`SCRB_A_EN3:    s_d.r.en3 = s_q.b.shift;
									`SCRB_A_EFF:    s_d.r.eff = s_q.b.shift;
									`SCRB_A_FMT:    s_d.r.fmt = s_q.b.shift;
									`SCRB_A_FST:    s_d.r.fst = s_q.b.shift;
									`SCRB_A_SYNC:   s_d.r.sync = s_q.b.shift;
									`SCRB_A_EN4:    s_d.r.en4 = s_q.b.shift[0];
									`SCRB_A_GATE:   s_d.r.gate = s_q.b.shift[1:0];
									`SCRB_A_BYP:    s_d.r.byp = s_q.b.shift;
									`SCRB_A_DBG2:   s_d.r.dbg2 = s_q.b.shift;
									`SCRB_A_PADDIR: s_d.r.paddir = s_q.b.shift[4:0];
									`SCRB_A_BUSOPEN: s_d.r.busopen = s_q.b.shift[0];
									`SCRB_A_PULL: begin
										if (s_q.b.shift[5:4] != `SCRB_PULL_ILLEGAL) begin
											s_d.r.pull = s_q.b.shift[5:4];
										end
										s_d.r.pwdn_pull = s_q.b.shift[0];
									end
									`SCRB_A_PLL1:   s_d.r.pll1 = s_q.b.shift;
									`SCRB_A_PLL2:   s_d.r.pll2 = s_q.b.shift;
									`SCRB_A_CLKEN:  s_d.r.clken = s_q.b.shift;
									`SCRB_A_CLKDIV: s_d.r.clkdiv = s_q.b.shift;
									`SCRB_A_APWR:   s_d.r.apwr = s_q.b.shift[2:0];
									`SCRB_A_SCALE:  s_d.r.scale = s_q.b.shift[1:0];
									`SCRB_A_RST:    s_d.r.rst = {s_q.b.shift[7:4], 1'b0,
										s_q.b.shift[2:0]};
									default: s_d.r = s_q.r;
								endcase
							end
						end
					end
				end
				scrb_pkg::ST_ACK: begin
					if (scl_fall) begin
						s_d.b.bit_cnt = 4'h0;
						s_d.b.shift = 8'h01;
						if (s_q.b.rd) begin
							s_d.b.st = scrb_pkg::ST_SEND;
							s_d.b.sda_oe = ~s_q.b.rdata[7];
						end else begin
							s_d.b.st = scrb_pkg::ST_DATA;
							s_d.b.sda_oe = 1'b0;
						end
					end
				end
				scrb_pkg::ST_SEND: begin
					if (scl_fall) begin
						s_d.b.rdata = {s_q.b.rdata[6:0], 1'b0};
						s_d.b.bit_cnt = s_q.b.bit_cnt + 4'h1;
						s_d.b.sda_oe = ~s_q.b.rdata[6];
						if (s_q.b.bit_cnt == 4'h7) begin
							s_d.b.st = scrb_pkg::ST_RACK;
							s_d.b.sda_oe = 1'b0;
						end
					end
				end
				scrb_pkg::ST_RACK: begin
					if (scl_rise) begin
						if (s_q.b.sda_sy[1]) begin
							s_d.b.st = scrb_pkg::ST_IDLE;
						end else begin
							s_d.b.ptr = s_q.b.ptr + 8'h01;
							s_d.b.rdata = rd_reg(s_q.r, s_q.b.ptr + 8'h01,
								page, i_exposure);
							s_d.b.bit_cnt = 4'h0;
						end
					end
					if (scl_fall && s_q.b.st == scrb_pkg::ST_RACK) begin
						s_d.b.st = scrb_pkg::ST_SEND;
						s_d.b.sda_oe = ~s_q.b.rdata[7];
					end
				end
				default: s_d.b.st = scrb_pkg::ST_IDLE;
			endcase
		end
		// control outputs decoded from the bank
		s_d.c.soft_rst    = s_q.r.rst[7];
		s_d.c.clk_rst     = s_q.r.rst[6];
		s_d.c.link_rst    = s_q.r.rst[5];
		s_d.c.restart_low = s_q.r.rst[4];
		s_d.c.pad_oe      = {{2{s_q.r.paddir[3]}}, s_q.r.paddir[2:0]};
		s_d.c.float_vb    = s_q.r.paddir[4];
		s_d.c.pull_dn     = s_q.r.pull == 2'h1;
		s_d.c.pull_up     = s_q.r.pull == 2'h2;
		s_d.c.pwdn_pull_en = ~s_q.r.pwdn_pull;
		s_d.c.synth_en    = s_q.r.pll1[0];
		s_d.c.halve_clock_enable = s_q.r.pll1[1];
		s_d.c.synth_bypass = s_q.r.clken[0];
		s_d.c.clk_en      = s_q.r.clken[7:2];
		s_d.c.apwr        = s_q.r.apwr;
		s_d.c.flip_rows   = s_q.r.flip[1];
		s_d.c.flip_cols   = s_q.r.flip[0];
		s_d.c.proc_en     = s_q.r.en1[6:0];
		s_d.c.effect      = s_q.r.eff[7:4];
		s_d.c.out_mode    = s_q.r.fmt[4:0];
		s_d.c.bayer_sel   = s_q.r.sync[5:4];
		s_d.c.byp_sel     = s_q.r.byp[1:0];
		s_d.c.sync_ctl    = s_q.r.sync[3:0];
		s_d.c.scale       = s_q.r.scale;
		s_d.c.gate        = s_q.r.gate;
		s_d.c.frame_rows  = ({1'b0, i_exposure} < vh_sum) ? vh_sum :
			{1'b0, i_exposure};
		if (s_q.r.rst[7]) begin
			s_d.r = regs_init();
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			s_q <= '0;
			s_q.b.scl_sy <= 3'h7;
			s_q.b.sda_sy <= 3'h7;
			s_q.b.st <= scrb_pkg::ST_IDLE;
			s_q.r <= regs_init();
		end else begin
			s_q <= s_d;
		end
	end

	assign o_sda_oe  = s_q.b.sda_oe;
	assign o_sda_out = 1'b0;
	assign o_ctl     = s_q.c;

	property p_frame;
		@(posedge i_mclk) disable iff (i_sys_rst)
		({1'b0, i_exposure} >= vh_sum) |=> o_ctl.frame_rows ==
			$past({1'b0, i_exposure});
	endproperty
	a_frame: assert property (p_frame) else $error("frame period wrong");

	property p_pull;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!(o_ctl.pull_dn && o_ctl.pull_up);
	endproperty
	a_pull: assert property (p_pull) else $error("both pulls on");

	property p_flip;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!i_sys_rst |=> o_ctl.flip_rows == $past(s_q.r.flip[1]);
	endproperty
	a_flip: assert property (p_flip) else $error("flip mismatch");

	property p_pwdn;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!i_sys_rst |=> o_ctl.pwdn_pull_en != $past(s_q.r.pwdn_pull);
	endproperty
	a_pwdn: assert property (p_pwdn) else $error("pwdn pull wrong");

	property p_ro;
		@(posedge i_mclk) disable iff (i_sys_rst)
		s_q.r.rst[3] == 1'b0;
	endproperty
	a_ro: assert property (p_ro) else $error("reserved bit set");

	property p_sda;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(s_q.b.st == scrb_pkg::ST_IDLE) |-> !o_sda_oe;
	endproperty
	a_sda: assert property (p_sda) else $error("drives idle bus");

	property p_gate;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!i_sys_rst |=> o_ctl.gate == $past(s_q.r.gate);
	endproperty
	a_gate: assert property (p_gate) else $error("gating mismatch");

	property p_sync;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!i_sys_rst |=> o_ctl.sync_ctl == $past(s_q.r.sync[3:0]);
	endproperty
	a_sync: assert property (p_sync) else $error("sync ctl mismatch");

	c_wr: cover property (@(posedge i_mclk) s_q.b.st == scrb_pkg::ST_DATA);
	c_rd: cover property (@(posedge i_mclk) s_q.b.st == scrb_pkg::ST_SEND);
	c_pg: cover property (@(posedge i_mclk) page == 3'h3);
endmodule // scrb_top

// ### verilog/scrb_params.svh
// register offsets, reset values and protocol constants for the control bank
`ifndef SCRB_PARAMS_SVH
`define SCRB_PARAMS_SVH
`define SCRB_WR_ADDR      8'h78
`define SCRB_RD_ADDR      8'h79
`define SCRB_SYS_BASE     8'hF0
`define SCRB_A_EXP_HI     8'h03
`define SCRB_A_EXP_LO     8'h04
`define SCRB_A_HB_HI      8'h05
`define SCRB_A_HB_LO      8'h06
`define SCRB_A_VB_HI      8'h07
`define SCRB_A_VB_LO      8'h08
`define SCRB_A_ROW_HI     8'h09
`define SCRB_A_ROW_LO     8'h0A
`define SCRB_A_COL_HI     8'h0B
`define SCRB_A_COL_LO     8'h0C
`define SCRB_A_WH_HI      8'h0D
`define SCRB_A_WH_LO      8'h0E
`define SCRB_A_WW_HI      8'h0F
`define SCRB_A_WW_LO      8'h10
`define SCRB_A_FLIP       8'h17
`define SCRB_A_SKIP       8'h18
`define SCRB_A_AN3        8'h20
`define SCRB_A_DRV        8'h24
`define SCRB_A_EN1        8'h80
`define SCRB_A_EN2        8'h81
`define SCRB_A_EN3        8'h82
`define SCRB_A_EFF        8'h83
`define SCRB_A_FMT        8'h84
`define SCRB_A_FST        8'h85
`define SCRB_A_SYNC       8'h86
`define SCRB_A_EN4        8'h87
`define SCRB_A_GATE       8'h88
`define SCRB_A_BYP        8'h89
`define SCRB_A_DBG2       8'h8C
`define SCRB_A_ID_HI      8'hF0
`define SCRB_A_ID_LO      8'hF1
`define SCRB_A_PADDIR     8'hF2
`define SCRB_A_BUSOPEN    8'hF3
`define SCRB_A_PULL       8'hF6
`define SCRB_A_PLL1       8'hF7
`define SCRB_A_PLL2       8'hF8
`define SCRB_A_CLKEN      8'hF9
`define SCRB_A_CLKDIV     8'hFA
`define SCRB_A_SLVADDR    8'hFB
`define SCRB_A_APWR       8'hFC
`define SCRB_A_SCALE      8'hFD
`define SCRB_A_RST        8'hFE
`define SCRB_R_HB_LO      8'hAA
`define SCRB_R_VB_LO      8'h0C
`define SCRB_R_COL_LO     8'h04
`define SCRB_R_WH_HI      8'h04
`define SCRB_R_WH_LO      8'hD0
`define SCRB_R_WW_HI      8'h03
`define SCRB_R_WW_LO      8'h28
`define SCRB_R_SKIP       8'h0A
`define SCRB_R_DRV        8'h55
`define SCRB_R_EN1        8'h08
`define SCRB_R_EN2        8'h28
`define SCRB_R_FMT        8'h02
`define SCRB_R_FST        8'h60
`define SCRB_R_SYNC       8'h0F
`define SCRB_R_GATE       8'h03
`define SCRB_R_BYP        8'h03
`define SCRB_R_PADDIR     8'h0F
`define SCRB_R_BUSOPEN    8'h01
`define SCRB_R_PLL1       8'h05
`define SCRB_R_PLL2       8'h81
`define SCRB_R_CLKEN      8'hFE
`define SCRB_R_CLKDIV     8'h11
`define SCRB_R_APWR       8'h06
`define SCRB_PULL_ILLEGAL 2'h3
`endif

// ### verilog/scrb_pkg.sv
// types for the sensor control register bank
package scrb_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_DATA,
		ST_SEND,
		ST_RACK
	} scrb_bus_e;

	typedef struct packed {
		logic [3:0] hb_hi;
		logic [7:0] hb_lo;
		logic [4:0] vb_hi;
		logic [7:0] vb_lo;
		logic [2:0] row_hi;
		logic [7:0] row_lo;
		logic [2:0] col_hi;
		logic [7:0] col_lo;
		logic [2:0] wh_hi;
		logic [7:0] wh_lo;
		logic [2:0] ww_hi;
		logic [7:0] ww_lo;
		logic [7:0] flip;
		logic [7:0] skip;
		logic [7:0] an3;
		logic [7:0] drv;
		logic [7:0] en1;
		logic [7:0] en2;
		logic [7:0] en3;
		logic [7:0] eff;
		logic [7:0] fmt;
		logic [7:0] fst;
		logic [7:0] sync;
		logic       en4;
		logic [1:0] gate;
		logic [7:0] byp;
		logic [7:0] dbg2;
		logic [4:0] paddir;
		logic       busopen;
		logic [1:0] pull;
		logic       pwdn_pull;
		logic [7:0] pll1;
		logic [7:0] pll2;
		logic [7:0] clken;
		logic [7:0] clkdiv;
		logic [2:0] apwr;
		logic [1:0] scale;
		logic [7:0] rst;
	} scrb_regs_s;

	typedef struct packed {
		logic [2:0] scl_sy;
		logic [2:0] sda_sy;
		scrb_bus_e  st;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic       got_addr;
		logic       rd;
		logic [7:0] ptr;
		logic       sda_oe;
		logic [7:0] rdata;
	} scrb_bus_s;

	typedef struct packed {
		logic        soft_rst;
		logic        clk_rst;
		logic        link_rst;
		logic        restart_low;
		logic [4:0]  pad_oe;
		logic        float_vb;
		logic        pull_dn;
		logic        pull_up;
		logic        pwdn_pull_en;
		logic        synth_en;
		logic        halve_clock_enable;
		logic        synth_bypass;
		logic [5:0]  clk_en;
		logic [2:0]  apwr;
		logic        flip_rows;
		logic        flip_cols;
		logic [6:0]  proc_en;
		logic [3:0]  effect;
		logic [4:0]  out_mode;
		logic [1:0]  bayer_sel;
		logic [1:0]  byp_sel;
		logic [3:0]  sync_ctl;
		logic [1:0]  scale;
		logic [1:0]  gate;
		logic [13:0] frame_rows;
	} scrb_ctl_s;

	typedef struct packed {
		scrb_regs_s r;
		scrb_bus_s  b;
		scrb_ctl_s  c;
	} scrb_state_s;
endpackage

// ### sim/scrb_host_model.sv
// two-wire bus master model for the control bank
`timescale 1ns/1ps
`include "scrb_params.svh"
module scrb_host_model #(
	parameter int QTR = 7
) (
	input  wire logic i_mclk,
	input  wire logic i_sda_w,
	output logic      o_scl,
	output logic      o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic q();
		repeat (QTR) @(posedge i_mclk);
	endtask
	task automatic start();
		o_sda_low <= 1'b0;
		q();
		o_scl <= 1'b1;
		q();
		o_sda_low <= 1'b1;
		q();
		o_scl <= 1'b0;
		q();
	endtask
	task automatic stop();
		o_sda_low <= 1'b1;
		q();
		o_scl <= 1'b1;
		q();
		o_sda_low <= 1'b0;
		q();
	endtask
	task automatic xfer_bit(input logic b, output logic s);
		o_sda_low <= ~b;
		q();
		o_scl <= 1'b1;
		q();
		s = i_sda_w;
		q();
		o_scl <= 1'b0;
		q();
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], s);
		end
		xfer_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic recv_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b1, d[i]);
		end
		xfer_bit(nack, s);
	endtask
	task automatic write(input logic [7:0] a, input logic [7:0] d,
			output logic ok);
		logic k0;
		logic k1;
		logic k2;
		start();
		send_byte(`SCRB_WR_ADDR, k0);
		send_byte(a, k1);
		send_byte(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] d,
			output logic ok);
		logic k0;
		logic k1;
		logic k2;
		start();
		send_byte(`SCRB_WR_ADDR, k0);
		send_byte(a, k1);
		start();
		send_byte(`SCRB_RD_ADDR, k2);
		recv_byte(1'b1, d);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule // scrb_host_model

// ### sim/tb_top.sv
// self-checking bench for the sensor control register bank
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0]   ID_HI = 8'h3C; // arbitrary value
	localparam logic [7:0]   ID_LO = 8'hC3; // arbitrary value
	localparam logic [335:0] RTAB  = {16'h06AA, 16'h080C, 16'h0C04,
		16'h0D04, 16'h0ED0, 16'h180A, 16'h2455, 16'h8008, 16'h8402,
		16'h8560, 16'h860F, 16'h8803, 16'h8903, 16'hF20F, 16'hF301,
		16'hF600, 16'hF705, 16'hF9FE, 16'hFB78, 16'hFC06, 16'hFE00};
	logic                i_mclk;
	logic                i_sys_rst;
	logic [12:0]         i_exposure;
	logic                scl;
	logic                host_low;
	logic                sda_oe;
	logic                sda_out;
	wire                 sda_w;
	scrb_pkg::scrb_ctl_s ctl;
	int                  fails = 0;
	int                  cmp_count = 0;
	int                  cyc = 0;
	assign sda_w = ~host_low & (sda_oe ? sda_out : 1'b1);
	scrb_top #(.ID_HI(ID_HI), .ID_LO(ID_LO)) scrb_top_inst (
		.i_mclk     (i_mclk),
		.i_sys_rst  (i_sys_rst),
		.i_scl      (scl),
		.i_sda      (sda_w),
		.o_sda_oe   (sda_oe),
		.o_sda_out  (sda_out),
		.i_exposure (i_exposure),
		.o_ctl      (ctl)
	);
	scrb_host_model scrb_host_model_inst (
		.i_mclk    (i_mclk),
		.i_sda_w   (sda_w),
		.o_scl     (scl),
		.o_sda_low (host_low)
	);
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 95000) begin
			fails++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s,
			input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		scrb_host_model_inst.write(a, d, ok);
		chk("write ack", {15'h0, ok}, 16'h0001);
		repeat (4) @(posedge i_mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		scrb_host_model_inst.read(a, d, ok);
		chk("read ack", {15'h0, ok}, 16'h0001);
		chk($sformatf("reg %h", a), {8'h0, d}, {8'h0, e});
	endtask
	task automatic t_reset();
		for (int i = 0; i < 21; i++) begin
			rd(RTAB[16*i+8 +: 8], RTAB[16*i +: 8]);
		end
		rd(8'hF0, ID_HI);
		rd(8'hF1, ID_LO);
		chk("gate", ctl.gate, 2'b11);
		chk("apwr", ctl.apwr, 3'b110);
		chk("sync", ctl.sync_ctl, 4'hF);
		chk("byp sel", ctl.byp_sel, 2'b11);
		chk("out mode", ctl.out_mode, 5'h02);
		chk("synth", {ctl.synth_en, ctl.halve_clock_enable}, 2'b10);
		chk("pull", {ctl.pull_dn, ctl.pull_up, ctl.pwdn_pull_en}, 3'b001);
		chk("clk en", ctl.clk_en, 6'h3F);
		chk("pads", {ctl.float_vb, ctl.pad_oe}, 6'h1F);
		$display("t_reset done");
	endtask
	task automatic t_frame();
		i_exposure <= 13'd256;
		repeat (4) @(posedge i_mclk);
		chk("frame rows", ctl.frame_rows, 14'd1244);
		i_exposure <= 13'd1245;
		repeat (4) @(posedge i_mclk);
		chk("frame rows", ctl.frame_rows, 14'd1245);
		i_exposure <= 13'h1234;
		repeat (4) @(posedge i_mclk);
		chk("frame rows", ctl.frame_rows, 14'd4660);
		rd(8'h03, 8'h12);
		wr(8'h04, 8'h00);
		rd(8'h04, 8'h34);
		$display("t_frame done");
	endtask
	task automatic t_burst();
		logic        ack;
		logic [31:0] d;
		d = 32'hFF5AFF33;
		scrb_host_model_inst.start();
		scrb_host_model_inst.send_byte(8'h78, ack);
		scrb_host_model_inst.send_byte(8'h05, ack);
		for (int i = 0; i < 4; i++) begin
			scrb_host_model_inst.send_byte(d[31-8*i -: 8], ack);
			chk("burst ack", ack, 1'b1);
		end
		scrb_host_model_inst.stop();
		rd(8'h05, 8'h0F);
		rd(8'h06, 8'h5A);
		rd(8'h07, 8'h1F);
		rd(8'h08, 8'h33);
		chk("frame rows", ctl.frame_rows, 14'd9219);
		$display("t_burst done");
	endtask
	task automatic t_pages();
		wr(8'hFE, 8'h01);
		rd(8'h84, 8'h00);
		rd(8'hF9, 8'hFE);
		rd(8'hFE, 8'h01);
		wr(8'hFE, 8'h03);
		rd(8'hFB, 8'h78);
		wr(8'hFE, 8'h00);
		rd(8'h84, 8'h02);
		$display("t_pages done");
	endtask
	task automatic t_modes();
		logic [34:0] fm;
		fm = {5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h0F, 5'h17};
		for (int i = 0; i < 7; i++) begin
			wr(8'h84, {3'b000, fm[5*i +: 5]});
			chk("out mode", ctl.out_mode, fm[5*i +: 5]);
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h86, {2'b00, i[1:0], i[0] ? 4'h5 : 4'hA});
			chk("bayer", ctl.bayer_sel, i[1:0]);
			chk("sync", ctl.sync_ctl, i[0] ? 4'h5 : 4'hA);
		end
		wr(8'h83, 8'h9F);
		chk("effect", ctl.effect, 4'h9);
		wr(8'h17, 8'h02);
		chk("flip", {ctl.flip_rows, ctl.flip_cols}, 2'b10);
		wr(8'h17, 8'h01);
		chk("flip", {ctl.flip_rows, ctl.flip_cols}, 2'b01);
		wr(8'h80, 8'h55);
		chk("proc en", ctl.proc_en, 7'h55);
		wr(8'h89, 8'h01);
		chk("byp sel", ctl.byp_sel, 2'b01);
		wr(8'hFD, 8'h02);
		chk("scale", ctl.scale, 2'b10);
		wr(8'h88, 8'hFD);
		rd(8'h88, 8'h01);
		chk("gate", ctl.gate, 2'b01);
		wr(8'hF7, 8'h02);
		chk("synth", {ctl.synth_en, ctl.halve_clock_enable}, 2'b01);
		wr(8'hF9, 8'h01);
		chk("synth bypass", ctl.synth_bypass, 1'b1);
		chk("clk en", ctl.clk_en, 6'h00);
		wr(8'hFC, 8'h01);
		chk("apwr", ctl.apwr, 3'b001);
		wr(8'hF2, 8'h10);
		chk("pads", {ctl.float_vb, ctl.pad_oe}, 6'h20);
		wr(8'hF6, 8'h11);
		chk("pull", {ctl.pull_dn, ctl.pull_up, ctl.pwdn_pull_en}, 3'b100);
		wr(8'hF6, 8'h20);
		chk("pull", {ctl.pull_dn, ctl.pull_up, ctl.pwdn_pull_en}, 3'b011);
		wr(8'hF6, 8'h30);
		rd(8'hF6, 8'h20);
		$display("t_modes done");
	endtask
	task automatic t_refuse();
		logic ack;
		scrb_host_model_inst.start();
		scrb_host_model_inst.send_byte(8'h7A, ack);
		scrb_host_model_inst.stop();
		chk("foreign ack", ack, 1'b0);
		wr(8'h30, 8'h77);
		rd(8'h30, 8'h00);
		wr(8'hFB, 8'h00);
		rd(8'hFB, 8'h78);
		$display("t_refuse done");
	endtask
	task automatic t_resets();
		logic ok;
		wr(8'hFE, 8'h70);
		chk("resets", {ctl.soft_rst, ctl.clk_rst, ctl.link_rst,
			ctl.restart_low}, 4'h7);
		wr(8'h84, 8'h06);
		scrb_host_model_inst.write(8'hFE, 8'h80, ok);
		repeat (4) @(posedge i_mclk);
		chk("soft reset", ctl.soft_rst, 1'b0);
		rd(8'h84, 8'h02);
		rd(8'hFE, 8'h00);
		$display("t_resets done");
	endtask
	initial begin
		i_sys_rst = 1'b1;
		i_exposure = 13'h0000;
		repeat (12) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		repeat (4) @(posedge i_mclk);
		t_reset();
		t_frame();
		t_burst();
		t_pages();
		t_modes();
		t_refuse();
		t_resets();
		end_sim();
	end
endmodule // tb_top
